/* File: core/mover_pkg.sv */
package mover_pkg;
   // Register indices on the software port
   localparam logic [2:0] REG_COUNT  = 3'h0;
   localparam logic [2:0] REG_CTRL   = 3'h1;
   localparam logic [2:0] REG_SRC    = 3'h2;
   localparam logic [2:0] REG_DST    = 3'h3;
   localparam logic [2:0] REG_BLOCK  = 3'h4;
   localparam logic [2:0] REG_STATUS = 3'h5;
   localparam logic [2:0] REG_MASK   = 3'h6;
   localparam logic [2:0] REG_STATE  = 3'h7;
   // Control byte field layout
   localparam int MODE_HI = 7;
   localparam int MODE_LO = 5;
   localparam int BIT_BW  = 4;
   localparam int BIT_SU  = 3;
   localparam int BIT_DU  = 2;
   localparam int BIT_SI  = 1;
   localparam int BIT_DI  = 0;
   localparam logic [2:0] MODE_SINGLE = 3'h4;
   localparam logic [2:0] MODE_BLOCK  = 3'h0;
   // Address steps per unit
   localparam logic [15:0] STEP_BYTE = 16'h0001;
   localparam logic [15:0] STEP_WORD = 16'h0002;
   // Reset values
   localparam logic [7:0]  RST_BYTE = 8'h00;
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [7:0]  ONE_BYTE = 8'h01;
   // Worst cycle length: four clocks per unit plus overhead
   localparam int CYC_PER_UNIT = 4;
   localparam int CYC_BUDGET   = CYC_PER_UNIT * 255 + 4;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ISSUE,
      ST_HOLD,
      ST_STORE,
      ST_STEP,
      ST_FINISH
   } state_t;
endpackage

/* File: core/interrupt_driven_block_mover.sv */
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/1ps
module interrupt_driven_block_mover #(
   parameter int AW = 16,
   parameter int DW = 16
) (
   input  wire logic          clk_sys_i,     // System clock, 200 MHz
   input  wire logic          reset_n_i,     // Async reset, active low
   input  wire logic [2:0]    reg_addr_i,    // Register index
   input  wire logic [15:0]   reg_wdata_i,   // Register write data
   input  wire logic          reg_wr_i,      // Register write strobe
   input  wire logic          reg_rd_i,      // Register read strobe
   output logic      [15:0]   reg_rdata_o,   // Read data, next cycle
   input  wire logic          xfer_req_i,    // Interrupt request pulse
   output logic               busy_o,        // Transfer cycle running
   output logic               irq_o,         // End-of-transfer interrupt
   output logic      [AW-1:0] mem_addr_o,    // Memory address
   output logic               mem_rd_o,      // Memory read strobe
   output logic               mem_wr_o,      // Memory write strobe
   output logic               mem_byte_o,    // High for byte unit
   output logic      [DW-1:0] mem_wdata_o,   // Memory write data
   input  wire logic [DW-1:0] mem_rdata_i    // Read data, cycle after strobe
);

   // Elaboration check on widths
   if (AW != 16 || DW != 16) begin : g_bad_width
      $error("Only 16-bit address and data are supported");
   end

   typedef struct packed {
      mover_pkg::state_t st;
      logic [7:0]        cnt;
      logic [7:0]        ctrl;
      logic [15:0]       src;
      logic [15:0]       dst;
      logic [7:0]        blk;
      logic [15:0]       osrc;
      logic [15:0]       odst;
      logic [7:0]        units;
      logic [15:0]       maddr;
      logic [15:0]       mwdata;
      logic              mrd;
      logic              mwr;
      logic              eot;
      logic              mask;
      logic [15:0]       rdata;
   } core_t;

   core_t q_r;
   core_t q_nxt;
   logic  rst_meta_r;
   logic  rst_sync_r;

   // Reset release through two flops
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end

   logic [2:0]  mode;
   logic        is_single;
   logic        is_block;
   logic [15:0] step;
   logic        wr_ok;

   // Control byte decode
   assign mode      = q_r.ctrl[mover_pkg::MODE_HI:mover_pkg::MODE_LO];
   assign is_single = (mode == mover_pkg::MODE_SINGLE);
   assign is_block  = (mode == mover_pkg::MODE_BLOCK);
   assign step      = q_r.ctrl[mover_pkg::BIT_BW] ? mover_pkg::STEP_BYTE
                                                  : mover_pkg::STEP_WORD;
   assign wr_ok     = reg_wr_i && (q_r.st == mover_pkg::ST_IDLE);

   // Next state of the whole block
   always_comb begin
      q_nxt     = q_r;
      q_nxt.mrd = 1'b0;
      q_nxt.mwr = 1'b0;
      // Register writes, control block only while idle
      if (wr_ok && reg_addr_i == mover_pkg::REG_COUNT) begin
         q_nxt.cnt = reg_wdata_i[7:0];
      end else if (wr_ok && reg_addr_i == mover_pkg::REG_CTRL) begin
         q_nxt.ctrl = reg_wdata_i[7:0];
      end else if (wr_ok && reg_addr_i == mover_pkg::REG_SRC) begin
         q_nxt.src = reg_wdata_i;
      end else if (wr_ok && reg_addr_i == mover_pkg::REG_DST) begin
         q_nxt.dst = reg_wdata_i;
      end else if (wr_ok && reg_addr_i == mover_pkg::REG_BLOCK) begin
         q_nxt.blk = reg_wdata_i[7:0];
      end else if (reg_wr_i && reg_addr_i == mover_pkg::REG_MASK) begin
         q_nxt.mask = reg_wdata_i[0];
      end
      // Read data, registered for the next cycle
      q_nxt.rdata = mover_pkg::RST_WORD;
      if (reg_rd_i) begin
         if (reg_addr_i == mover_pkg::REG_COUNT) begin
            q_nxt.rdata = {8'h00, q_r.cnt};
         end else if (reg_addr_i == mover_pkg::REG_CTRL) begin
            q_nxt.rdata = {8'h00, q_r.ctrl};
         end else if (reg_addr_i == mover_pkg::REG_SRC) begin
            q_nxt.rdata = q_r.src;
         end else if (reg_addr_i == mover_pkg::REG_DST) begin
            q_nxt.rdata = q_r.dst;
         end else if (reg_addr_i == mover_pkg::REG_BLOCK) begin
            q_nxt.rdata = {8'h00, q_r.blk};
         end else if (reg_addr_i == mover_pkg::REG_STATUS) begin
            q_nxt.rdata = {15'h0000, q_r.eot};
            q_nxt.eot   = 1'b0;
         end else if (reg_addr_i == mover_pkg::REG_MASK) begin
            q_nxt.rdata = {15'h0000, q_r.mask};
         end else begin
            q_nxt.rdata = {15'h0000, busy_o};
         end
      end
      // Transfer sequencer
      case (q_r.st)
         mover_pkg::ST_IDLE: begin
            if (xfer_req_i && q_r.cnt != mover_pkg::RST_BYTE
                && (is_single || is_block)) begin
               q_nxt.osrc  = q_r.src;
               q_nxt.odst  = q_r.dst;
               q_nxt.units = is_block ? q_r.blk : mover_pkg::ONE_BYTE;
               q_nxt.st    = (is_block && q_r.blk == mover_pkg::RST_BYTE)
                             ? mover_pkg::ST_FINISH : mover_pkg::ST_ISSUE;
            end
         end
         mover_pkg::ST_ISSUE: begin
            q_nxt.mrd   = 1'b1;
            q_nxt.maddr = q_r.src;
            q_nxt.st    = mover_pkg::ST_HOLD;
         end
         mover_pkg::ST_HOLD: begin
            q_nxt.st = mover_pkg::ST_STORE;
         end
         mover_pkg::ST_STORE: begin
            q_nxt.mwdata = mem_rdata_i;
            q_nxt.mwr    = 1'b1;
            q_nxt.maddr  = q_r.dst;
            q_nxt.st     = mover_pkg::ST_STEP;
         end
         mover_pkg::ST_STEP: begin
            // Per-unit address advance
            if (q_r.ctrl[mover_pkg::BIT_SI]) begin
               q_nxt.src = q_r.src + step;
            end
            if (q_r.ctrl[mover_pkg::BIT_DI]) begin
               q_nxt.dst = q_r.dst + step;
            end
            q_nxt.units = q_r.units - mover_pkg::ONE_BYTE;
            q_nxt.st    = (q_r.units == mover_pkg::ONE_BYTE)
                          ? mover_pkg::ST_FINISH : mover_pkg::ST_ISSUE;
         end
         mover_pkg::ST_FINISH: begin
            // Reload pointers whose retain bit is clear
            if (!q_r.ctrl[mover_pkg::BIT_SU]) begin
               q_nxt.src = q_r.osrc;
            end
            if (!q_r.ctrl[mover_pkg::BIT_DU]) begin
               q_nxt.dst = q_r.odst;
            end
            q_nxt.cnt = q_r.cnt - mover_pkg::ONE_BYTE;
            if (q_r.cnt == mover_pkg::ONE_BYTE) begin
               q_nxt.eot = 1'b1;
            end
            q_nxt.st = mover_pkg::ST_IDLE;
         end
         default: begin
            q_nxt.st = mover_pkg::ST_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge clk_sys_i or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         q_r <= '{st: mover_pkg::ST_IDLE, cnt: mover_pkg::RST_BYTE,
                  ctrl: mover_pkg::RST_BYTE, src: mover_pkg::RST_WORD,
                  dst: mover_pkg::RST_WORD, blk: mover_pkg::RST_BYTE,
                  osrc: mover_pkg::RST_WORD, odst: mover_pkg::RST_WORD,
                  units: mover_pkg::RST_BYTE, maddr: mover_pkg::RST_WORD,
                  mwdata: mover_pkg::RST_WORD, mrd: 1'b0, mwr: 1'b0,
                  eot: 1'b0, mask: 1'b0, rdata: mover_pkg::RST_WORD};
      end else begin
         q_r <= q_nxt;
      end
   end

   // Outputs
   assign busy_o      = (q_r.st != mover_pkg::ST_IDLE);
   assign irq_o       = q_r.eot && q_r.mask;
   assign reg_rdata_o = q_r.rdata;
   assign mem_addr_o  = q_r.maddr;
   assign mem_rd_o    = q_r.mrd;
   assign mem_wr_o    = q_r.mwr;
   assign mem_byte_o  = q_r.ctrl[mover_pkg::BIT_BW];
   assign mem_wdata_o = q_r.mwdata;

   // Helper counters for checks
   logic [7:0]  wr_seen_r;
   logic [11:0] busy_len_r;
   always_ff @(posedge clk_sys_i or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         wr_seen_r  <= 8'h00;
         busy_len_r <= 12'h000;
      end else begin
         if (q_r.st == mover_pkg::ST_IDLE) begin
            wr_seen_r  <= 8'h00;
            busy_len_r <= 12'h000;
         end else begin
            wr_seen_r  <= wr_seen_r + {7'h00, q_r.mwr};
            busy_len_r <= busy_len_r + 12'h001;
         end
      end
   end

   chk_eot_on_zero: assert property (
      @(posedge clk_sys_i) disable iff (!rst_sync_r)
      (q_r.st == mover_pkg::ST_FINISH && q_r.cnt == mover_pkg::ONE_BYTE) |=> (q_r.eot && !busy_o))
      else $error("End-of-transfer flag not set at zero count");

   chk_count_decrement: assert property (
      @(posedge clk_sys_i) disable iff (!rst_sync_r)
      (q_r.st == mover_pkg::ST_FINISH) |=> (q_r.cnt == $past(q_r.cnt) - mover_pkg::ONE_BYTE))
      else $error("Count not decremented once per cycle");

   chk_single_one_unit: assert property (
      @(posedge clk_sys_i) disable iff (!rst_sync_r)
      (q_r.st == mover_pkg::ST_ISSUE && is_single)
      |=> mem_rd_o ##2 mem_wr_o ##1 (q_r.st == mover_pkg::ST_FINISH))
      else $error("Single cycle did not move exactly one unit");

   chk_word_step_two: assert property (
      @(posedge clk_sys_i) disable iff (!rst_sync_r)
      (q_r.st == mover_pkg::ST_STEP && !q_r.ctrl[mover_pkg::BIT_BW]
       && q_r.ctrl[mover_pkg::BIT_DI])
      |=> (q_r.dst == $past(q_r.dst) + mover_pkg::STEP_WORD))
      else $error("Word step did not advance by two");

   chk_fixed_source: assert property (
      @(posedge clk_sys_i) disable iff (!rst_sync_r)
      (q_r.st == mover_pkg::ST_STEP && !q_r.ctrl[mover_pkg::BIT_SI]) |=> $stable(q_r.src))
      else $error("Source moved with increment disabled");

   chk_source_restore: assert property (
      @(posedge clk_sys_i) disable iff (!rst_sync_r)
      (q_r.st == mover_pkg::ST_FINISH && !q_r.ctrl[mover_pkg::BIT_SU])
      |=> (q_r.src == q_r.osrc))
      else $error("Source not reloaded at end of cycle");

   chk_block_units: assert property (
      @(posedge clk_sys_i) disable iff (!rst_sync_r)
      (q_r.st == mover_pkg::ST_FINISH && is_block) |-> (wr_seen_r == q_r.blk))
      else $error("Block cycle moved wrong number of units");

   chk_busy_hold: assert property (
      @(posedge clk_sys_i) disable iff (!rst_sync_r)
      (busy_o && q_r.st != mover_pkg::ST_FINISH) |=> busy_o)
      else $error("Transfer cycle ended early");

   chk_cycle_length: assert property (
      @(posedge clk_sys_i) disable iff (!rst_sync_r)
      busy_len_r <= 12'(mover_pkg::CYC_BUDGET))
      else $error("Transfer cycle exceeded its length budget");

   chk_idle_zero_count: assert property (
      @(posedge clk_sys_i) disable iff (!rst_sync_r)
      (!busy_o && xfer_req_i && q_r.cnt == mover_pkg::RST_BYTE) |=> !busy_o)
      else $error("Cycle started with zero count");

   // Checks on pointer updates, status, start decisions, count and control holds, memory strobes and read data
   chk_src_step_unit: assert property (
      @(posedge clk_sys_i) disable iff (!rst_sync_r)
      (q_r.st == mover_pkg::ST_STEP && q_r.ctrl[mover_pkg::BIT_SI])
      |=> (q_r.src == $past(q_r.src) + $past(step)))
      else $error("Source did not advance by one unit");

   chk_byte_step_one: assert property (
      @(posedge clk_sys_i) disable iff (!rst_sync_r)
      (q_r.st == mover_pkg::ST_STEP && q_r.ctrl[mover_pkg::BIT_BW]
       && q_r.ctrl[mover_pkg::BIT_DI])
      |=> (q_r.dst == $past(q_r.dst) + mover_pkg::STEP_BYTE))
      else $error("Byte step did not advance by one");

   chk_fixed_dest: assert property (
      @(posedge clk_sys_i) disable iff (!rst_sync_r)
      (q_r.st == mover_pkg::ST_STEP && !q_r.ctrl[mover_pkg::BIT_DI]) |=> $stable(q_r.dst))
      else $error("Destination moved with increment disabled");

   chk_dst_restore: assert property (
      @(posedge clk_sys_i) disable iff (!rst_sync_r)
      (q_r.st == mover_pkg::ST_FINISH && !q_r.ctrl[mover_pkg::BIT_DU])
      |=> (q_r.dst == q_r.odst))
      else $error("Destination not reloaded at end of cycle");

   chk_eot_hold: assert property (
      @(posedge clk_sys_i) disable iff (!rst_sync_r)
      (q_r.eot && !(reg_rd_i && reg_addr_i == mover_pkg::REG_STATUS)) |=> q_r.eot)
      else $error("End-of-transfer flag lost without a status read");

   chk_status_clear: assert property (
      @(posedge clk_sys_i) disable iff (!rst_sync_r)
      (reg_rd_i && reg_addr_i == mover_pkg::REG_STATUS
       && !(q_r.st == mover_pkg::ST_FINISH && q_r.cnt == mover_pkg::ONE_BYTE))
      |=> !q_r.eot)
      else $error("Status read did not clear the flag");

   chk_mode_refused: assert property (
      @(posedge clk_sys_i) disable iff (!rst_sync_r)
      (!busy_o && xfer_req_i && !is_single && !is_block) |=> !busy_o)
      else $error("Cycle started in an unsupported mode");

   chk_start_taken: assert property (
      @(posedge clk_sys_i) disable iff (!rst_sync_r)
      (!busy_o && xfer_req_i && q_r.cnt != mover_pkg::RST_BYTE && (is_single || is_block))
      |=> busy_o)
      else $error("Valid request did not start a cycle");

   chk_count_hold: assert property (
      @(posedge clk_sys_i) disable iff (!rst_sync_r)
      (busy_o && q_r.st != mover_pkg::ST_FINISH) |=> $stable(q_r.cnt))
      else $error("Count changed inside a transfer cycle");

   chk_ctrl_frozen: assert property (
      @(posedge clk_sys_i) disable iff (!rst_sync_r)
      busy_o |=> $stable(q_r.ctrl))
      else $error("Control byte changed during a cycle");

   chk_strobe_exclusive: assert property (
      @(posedge clk_sys_i) disable iff (!rst_sync_r)
      !(mem_rd_o && mem_wr_o))
      else $error("Memory read and write strobes together");

   chk_read_then_write: assert property (
      @(posedge clk_sys_i) disable iff (!rst_sync_r)
      mem_rd_o |-> ##2 mem_wr_o)
      else $error("Read not followed by its write");

   chk_read_address: assert property (
      @(posedge clk_sys_i) disable iff (!rst_sync_r)
      mem_rd_o |-> (mem_addr_o == q_r.src))
      else $error("Read not at current source");

   chk_write_address: assert property (
      @(posedge clk_sys_i) disable iff (!rst_sync_r)
      mem_wr_o |-> (mem_addr_o == q_r.dst))
      else $error("Write not at current destination");

   chk_rdata_idle: assert property (
      @(posedge clk_sys_i) disable iff (!rst_sync_r)
      !reg_rd_i |=> (reg_rdata_o == mover_pkg::RST_WORD))
      else $error("Read data not zero outside a read");

endmodule

/* File: tb/far_memory.sv */
`timescale 1ns/1ps
module far_memory (
   input  wire logic        clk_sys_i,   // System clock
   input  wire logic [15:0] mem_addr_i,  // Read address
   input  wire logic        mem_rd_i,    // Read strobe
   output logic      [15:0] mem_rdata_o  // Valid the cycle after strobe
);
   // Address pattern after a read, inverted data otherwise
   initial mem_rdata_o = 16'h0000;
   always @(posedge clk_sys_i) begin
      if (mem_rd_i) begin
         mem_rdata_o <= mem_addr_i ^ 16'hA5C3;
      end else begin
         mem_rdata_o <= ~mem_rdata_o;
      end
   end
endmodule

/* File: tb/tb_interrupt_driven_block_mover.sv */
`timescale 1ns/1ps
module tb_interrupt_driven_block_mover;
   logic        clk_sys_i   = 1'b0;
   logic        reset_n_i   = 1'b0;
   logic [2:0]  reg_addr_i  = 3'h0;
   logic [15:0] reg_wdata_i = 16'h0000;
   logic        reg_wr_i    = 1'b0;
   logic        reg_rd_i    = 1'b0;
   logic        xfer_req_i  = 1'b0;
   logic        rd_d        = 1'b0;
   logic [15:0] reg_rdata_o, mem_addr_o, mem_wdata_o, mem_rdata_i;
   logic        busy_o, irq_o, mem_rd_o, mem_wr_o, mem_byte_o;
   logic [32:0] wq[$];
   logic [15:0] rq[$];
   int          failures     = 0;
   int          total_checks = 0;
   int          i;
   logic [7:0]  c;

   // Clock, 5 ns period
   initial begin
      forever #2.5 clk_sys_i = ~clk_sys_i;
   end

   interrupt_driven_block_mover u_dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .xfer_req_i(xfer_req_i),
      .busy_o(busy_o), .irq_o(irq_o), .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o),
      .mem_wr_o(mem_wr_o), .mem_byte_o(mem_byte_o), .mem_wdata_o(mem_wdata_o),
      .mem_rdata_i(mem_rdata_i));
   far_memory u_mem (.clk_sys_i(clk_sys_i), .mem_addr_i(mem_addr_o), .mem_rd_i(mem_rd_o),
      .mem_rdata_o(mem_rdata_i));

   // Compare tasks
   task cmp_val(input logic [15:0] e, input logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         failures++;
         $display("unexpected at %0t: exp %h got %h", $time, e, g);
      end
   endtask
   task cmp_mem(input logic [32:0] e);
      logic [15:0] m;
      m = e[32] ? 16'h00FF : 16'hFFFF;
      total_checks++;
      if ({mem_byte_o, mem_addr_o, mem_wdata_o & m} !== {e[32:16], e[15:0] & m}) begin
         failures++;
         $display("unexpected at %0t: exp %h got %h", $time, e,
                  {mem_byte_o, mem_addr_o, mem_wdata_o});
      end
   endtask

   // Watcher takes the oldest note per result
   always @(posedge clk_sys_i) begin
      if (rd_d) begin
         cmp_val(rq.pop_front(), reg_rdata_o);
      end
      if (mem_wr_o && wq.size() == 0) begin
         failures++;
         $display("unexpected at %0t: exp %h got %h", $time, 16'h0000, mem_addr_o);
      end else if (mem_wr_o) begin
         cmp_mem(wq.pop_front());
      end
      rd_d <= reg_rd_i;
   end

   // Register bus cycles
   task wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge clk_sys_i);
      reg_wr_i    <= 1'b1;
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      @(posedge clk_sys_i);
      reg_wr_i <= 1'b0;
   endtask
   task rd(input logic [2:0] a, input logic [15:0] e);
      rq.push_back(e);
      @(posedge clk_sys_i);
      reg_rd_i   <= 1'b1;
      reg_addr_i <= a;
      @(posedge clk_sys_i);
      reg_rd_i <= 1'b0;
   endtask

   // Request, a stray request while busy, wait for idle
   task fire(input logic exp_busy);
      int k;
      @(posedge clk_sys_i);
      xfer_req_i <= 1'b1;
      @(posedge clk_sys_i);
      xfer_req_i <= 1'b0;
      for (k = 0; k < 2000; k++) begin
         @(posedge clk_sys_i);
         if (k == 0) begin
            cmp_val({15'h0000, exp_busy}, {15'h0000, busy_o});
         end
         // Stray request and refused count write, only while busy
         xfer_req_i  <= (k == 1) && busy_o;
         reg_wr_i    <= (k == 1) && busy_o;
         reg_addr_i  <= mover_pkg::REG_COUNT;
         reg_wdata_i <= 16'h00FF;
         if (busy_o !== 1'b1) break;
      end
   endtask

   // Program a control block, predict writes, run all cycles
   task run(input logic [7:0] cb, input logic [7:0] n, input logic [7:0] b,
            input logic [15:0] s, input logic [15:0] d, input logic m);
      logic [15:0] st, os, od;
      int          k, j, u;
      wr(mover_pkg::REG_MASK, {15'h0000, m});
      wr(mover_pkg::REG_COUNT, {8'h00, n});
      wr(mover_pkg::REG_CTRL, {8'h00, cb});
      wr(mover_pkg::REG_SRC, s);
      wr(mover_pkg::REG_DST, d);
      wr(mover_pkg::REG_BLOCK, {8'h00, b});
      st = cb[mover_pkg::BIT_BW] ? mover_pkg::STEP_BYTE : mover_pkg::STEP_WORD;
      u = (cb[mover_pkg::MODE_HI:mover_pkg::MODE_LO] == mover_pkg::MODE_SINGLE) ? 1 : b;
      for (k = 0; k < n; k++) begin
         os = s;
         od = d;
         for (j = 0; j < u; j++) begin
            wq.push_back({cb[mover_pkg::BIT_BW], d, s ^ 16'hA5C3});
            s = s + (cb[mover_pkg::BIT_SI] ? st : 16'h0000);
            d = d + (cb[mover_pkg::BIT_DI] ? st : 16'h0000);
         end
         s = cb[mover_pkg::BIT_SU] ? s : os;
         d = cb[mover_pkg::BIT_DU] ? d : od;
         fire(1'b1);
      end
      fire(1'b0);
      cmp_val(16'h0000, 16'(wq.size()));
      cmp_val({15'h0000, m}, {15'h0000, irq_o});
      rd(mover_pkg::REG_SRC, s);
      rd(mover_pkg::REG_DST, d);
      rd(mover_pkg::REG_COUNT, 16'h0000);
      rd(mover_pkg::REG_STATUS, 16'h0001);
      rd(mover_pkg::REG_STATUS, 16'h0000);
      cmp_val(16'h0000, {15'h0000, irq_o});
      $display("test done: ctrl %h count %h", cb, n);
   endtask

   // Verdict and end of run
   task test_done;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Watchdog
   initial begin
      #500000;
      failures++;
      test_done();
   end

   // Main sequence
   initial begin
      i = $urandom(39);
      repeat (6) @(posedge clk_sys_i);
      reset_n_i <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      for (i = 0; i < 8; i++) begin
         rd(i[2:0], 16'h0000);
      end
      wr(mover_pkg::REG_STATUS, 16'h0001);
      rd(mover_pkg::REG_STATUS, 16'h0000);
      $display("test done: reset values");
      run(8'h85, 8'h09, 8'h00, 16'h0020, 16'h6000, 1'b1);
      run(8'h17, 8'h03, 8'h05, 16'h0020, 16'h6000, 1'b0);
      // Unsupported mode code is refused, count kept
      wr(mover_pkg::REG_CTRL, 16'h0023);
      wr(mover_pkg::REG_COUNT, 16'h0002);
      fire(1'b0);
      rd(mover_pkg::REG_COUNT, 16'h0002);
      $display("test done: refused mode");
      // Block size zero moves nothing, count still runs down
      run(8'h03, 8'h02, 8'h00, 16'h0100, 16'h0200, 1'b1);
      for (i = 0; i < 6; i++) begin
         c = 8'($urandom);
         c[7:5] = i[0] ? mover_pkg::MODE_SINGLE : mover_pkg::MODE_BLOCK;
         c[3] = i[0] ? c[1] : c[3];
         c[2] = i[0] ? c[0] : c[2];
         run(c, 8'($urandom_range(3, 1)), 8'($urandom_range(4, 1)), 16'($urandom),
             16'($urandom), i[1]);
      end
      test_done();
   end
endmodule
